// ---- hdl/wic_top.sv ----
/*
  wake-up and interrupt control: operating mode, pin and timer wake,
  oscillator settling, request flags, enables and vectoring.
  assumes an Avalon-MM master with word addresses, a core that pulses
  i_return_from_irq on return_from_irq, and timer/oscillator pulses on i_mclk.
*/
// The Avalon-MM register port was left to the implementer.
`timescale 1ns/10ps
module wic_top
  import wic_pkg::*;
#(
  parameter int WAKE_COUNT = WAKE_CLOCKS
) (
  input  wire logic              i_mclk,
  input  wire logic              i_rstn,
  input  wire logic [ADDR_W-1:0] i_avs_address,
  input  wire logic              i_avs_read,
  input  wire logic              i_avs_write,
  input  wire logic [7:0]        i_avs_writedata,
  output logic      [7:0]        o_avs_readdata,
  output logic                   o_avs_waitrequest,
  input  wire logic [7:0]        i_port0,
  input  wire logic [7:0]        i_port1,
  input  wire logic              i_timer0_ovf,
  input  wire logic              i_hosc_tick,
  input  wire logic              i_return_from_irq,
  output logic                   o_core_run,
  output logic                   o_hosc_enable,
  output logic                   o_vector_load,
  output logic      [PC_W-1:0]   o_vector_addr,
  output logic                   o_stack_push
);
  wic_mode_type mode;
  wic_mode_type next_mode;
  logic         green_from_slow;
  logic [7:0]   port1_wake_enable;
  logic [1:0]   ext_edge_select;
  logic         ext_irq_enable;
  logic         timer0_irq_enable;
  logic         ext_irq_flag;
  logic         timer_zero_irq_flag;
  logic         global_irq_enable;
  logic [1:0]   stack_bits;
  logic         in_service;
  logic         rd_valid;
  logic [7:0]   p0_level;
  logic [7:0]   p0_change;
  logic [7:0]   p1_level;
  logic [7:0]   p1_change;
  logic         warm_done;

  // ==========================================================
  // pin synchronisers and settling counter
  wic_pin_sync #(.W(8)) u_p0 (
    .i_mclk   (i_mclk),
    .i_rstn   (i_rstn),
    .i_pin    (i_port0),
    .o_level  (p0_level),
    .o_change (p0_change)
  );

  wic_pin_sync #(.W(8)) u_p1 (
    .i_mclk   (i_mclk),
    .i_rstn   (i_rstn),
    .i_pin    (i_port1),
    .o_level  (p1_level),
    .o_change (p1_change)
  );

  wic_osc_wait #(.COUNT(WAKE_COUNT)) u_warm (
    .i_mclk (i_mclk),
    .i_rstn (i_rstn),
    .i_run  (mode == ST_WARM),
    .i_tick (i_hosc_tick),
    .o_done (warm_done)
  );

  // ==========================================================
  // bus decode
  wire wr_edge  = i_avs_write && (i_avs_address == IDX_EDGE);
  wire wr_p1w   = i_avs_write && (i_avs_address == IDX_P1WAKE);
  wire wr_req   = i_avs_write && (i_avs_address == IDX_IRQ_REQ);
  wire wr_en    = i_avs_write && (i_avs_address == IDX_IRQ_EN);
  wire wr_stack = i_avs_write && (i_avs_address == IDX_STACK);
  wire wr_mode  = i_avs_write && (i_avs_address == IDX_MODE);

  // reads take one extra cycle so data come from a flop
  assign o_avs_waitrequest = i_avs_read && !rd_valid;

  // p1w is write-only and reads back zero; unmapped reads give zero
  wire [7:0] rd_mux =
    (i_avs_address == IDX_EDGE)    ? {3'h0, ext_edge_select, 3'h0} :
    (i_avs_address == IDX_IRQ_REQ) ? {3'h0, timer_zero_irq_flag, 3'h0, ext_irq_flag} :
    (i_avs_address == IDX_IRQ_EN)  ? {3'h0, timer0_irq_enable, 3'h0, ext_irq_enable} :
    (i_avs_address == IDX_STACK)   ? {global_irq_enable, 5'h00, stack_bits} :
    (i_avs_address == IDX_MODE)    ? {3'h0, mode} :
    8'h00;

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      rd_valid       <= 1'b0;
      o_avs_readdata <= 8'h00;
    end else begin
      rd_valid       <= i_avs_read && !rd_valid;
      o_avs_readdata <= rd_mux;
    end
  end

  // ==========================================================
  // wake sources
  wire p1_wake    = |(p1_change & port1_wake_enable);
  wire pin_change = (|p0_change) || p1_wake;
  wire running    = (mode == ST_NORMAL) || (mode == ST_SLOW);
  assign o_core_run    = running;
  assign o_hosc_enable = (mode != ST_SLEEP);

  // ==========================================================
  // operating mode sequence
  always_comb begin
    next_mode = mode;
    case (mode)
      ST_NORMAL, ST_SLOW: begin
        if (wr_mode && i_avs_writedata[MODE_SLEEP]) begin
          next_mode = ST_SLEEP;
        end else if (wr_mode && i_avs_writedata[MODE_GREEN]) begin
          next_mode = ST_GREEN;
        end else if (wr_mode) begin
          next_mode = i_avs_writedata[MODE_SLOW] ? ST_SLOW : ST_NORMAL;
        end
      end
      ST_SLEEP: begin
        // timer overflow is ignored here: only pins, then settle
        if (pin_change) begin
          next_mode = ST_WARM;
        end
      end
      ST_WARM: begin
        if (warm_done) begin
          next_mode = ST_NORMAL;
        end
      end
      ST_GREEN: begin
        // clock kept running, so no settling wait
        if (pin_change || i_timer0_ovf) begin
          next_mode = green_from_slow ? ST_SLOW : ST_NORMAL;
        end
      end
      default: next_mode = ST_NORMAL;
    endcase
  end

  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      mode            <= ST_NORMAL;
      green_from_slow <= 1'b0;
    end else begin
      mode <= next_mode;
      if (running && next_mode == ST_GREEN) begin
        green_from_slow <= (mode == ST_SLOW);
      end
    end
  end

  // ==========================================================
  // configuration registers
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      port1_wake_enable <= P1WAKE_RST;
      ext_edge_select   <= EDGE_RST;
      ext_irq_enable    <= 1'b0;
      timer0_irq_enable <= 1'b0;
    end else begin
      if (wr_p1w) begin
        port1_wake_enable <= i_avs_writedata;
      end
      if (wr_edge) begin
        ext_edge_select <= i_avs_writedata[EDGE_LSB+1:EDGE_LSB];
      end
      if (wr_en) begin
        ext_irq_enable    <= i_avs_writedata[BIT_EXT];
        timer0_irq_enable <= i_avs_writedata[BIT_T0];
      end
    end
  end

  // ==========================================================
  // external edge detection; code 00 is reserved and never fires
  wire ext_rise = p0_change[0] && p0_level[0];
  wire ext_fall = p0_change[0] && !p0_level[0];
  wire ext_event =
    (ext_rise && (ext_edge_select == EDGE_RISE || ext_edge_select == EDGE_BOTH)) ||
    (ext_fall && (ext_edge_select == EDGE_FALL || ext_edge_select == EDGE_BOTH));

  // ==========================================================
  // request flags: hardware set beats a software clear in the same cycle,
  // so an edge latched during sleep is serviced after wake
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      ext_irq_flag        <= 1'b0;
      timer_zero_irq_flag <= 1'b0;
    end else begin
      if (ext_event) begin
        ext_irq_flag <= 1'b1;
      end else if (wr_req) begin
        ext_irq_flag <= i_avs_writedata[BIT_EXT];
      end
      if (i_timer0_ovf) begin
        timer_zero_irq_flag <= 1'b1;
      end else if (wr_req) begin
        timer_zero_irq_flag <= i_avs_writedata[BIT_T0];
      end
    end
  end

  // ==========================================================
  // interrupt take and return
  wire src_pending = (ext_irq_flag && ext_irq_enable) ||
                     (timer_zero_irq_flag && timer0_irq_enable);
  wire take        = running && global_irq_enable && src_pending;
  wire leave       = in_service && i_return_from_irq;

  // global enable lives in the stack pointer register
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      global_irq_enable <= 1'b0;
      stack_bits        <= STACK_POINTER_REG_RST;
      in_service        <= 1'b0;
    end else begin
      if (take) begin
        global_irq_enable <= 1'b0;
      end else if (leave) begin
        global_irq_enable <= 1'b1;
      end else if (wr_stack) begin
        global_irq_enable <= i_avs_writedata[BIT_GIE];
      end
      if (wr_stack) begin
        stack_bits <= i_avs_writedata[1:0];
      end
      if (take) begin
        in_service <= 1'b1;
      end else if (leave) begin
        in_service <= 1'b0;
      end
    end
  end

  // vector and push are single-cycle strobes to the core
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_vector_load <= 1'b0;
      o_stack_push  <= 1'b0;
      o_vector_addr <= '0;
    end else begin
      o_vector_load <= take;
      o_stack_push  <= take;
      if (take) begin
        o_vector_addr <= VECTOR_ADDR;
      end
    end
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (!i_rstn);

  a_halt_no_run: assert property (
    (mode == ST_SLEEP || mode == ST_GREEN) |-> !o_core_run)
    else $error("core runs while halted");
  a_sleep_ignores_timer: assert property (
    (mode == ST_SLEEP && !pin_change) |=> mode == ST_SLEEP)
    else $error("sleep left without pin change");
  a_green_resume: assert property (
    (mode == ST_GREEN && (pin_change || i_timer0_ovf))
      |=> (mode == (green_from_slow ? ST_SLOW : ST_NORMAL)))
    else $error("green did not resume prior mode");
  a_warm_wait: assert property (
    (mode == ST_SLEEP && pin_change) |=> (mode == ST_WARM) ##1 (mode == ST_WARM))
    else $error("no settling wait after sleep");
  a_osc_halted: assert property (
    mode == ST_SLEEP |-> !o_hosc_enable)
    else $error("oscillator running in sleep");
  a_wake_mask: assert property (
    (mode == ST_SLEEP && p0_change == 8'h00 && p1_wake == 1'b0) |=> mode == ST_SLEEP)
    else $error("masked port 1 pin woke device");
  a_take_vector: assert property (
    take |=> o_vector_load && o_stack_push && o_vector_addr == VECTOR_ADDR && !global_irq_enable)
    else $error("vector or gie wrong after take");
  a_gie_return: assert property (
    leave |=> global_irq_enable && !in_service)
    else $error("gie not restored on return");
  a_gie_needed: assert property (
    o_vector_load |-> $past(global_irq_enable) && $past(src_pending))
    else $error("vectored without enables");
  a_flag_set: assert property (
    i_timer0_ovf |=> timer_zero_irq_flag)
    else $error("timer flag not set");
endmodule

// ---- include/wic_pkg.sv ----
/*
  constants, field positions, reset values and mode codes for the
  wake-up and interrupt control block.
  assumes register indices are used as Avalon word addresses.
*/
package wic_pkg;

  // ==========================================================
  // register indices (Avalon word addresses)
  localparam int          ADDR_W       = 8;
  localparam logic [7:0]  IDX_EDGE     = 8'hBF;
  localparam logic [7:0]  IDX_P1WAKE   = 8'hC0;
  localparam logic [7:0]  IDX_IRQ_REQ  = 8'hC8;
  localparam logic [7:0]  IDX_IRQ_EN   = 8'hC9;
  localparam logic [7:0]  IDX_STACK    = 8'hDF;
  localparam logic [7:0]  IDX_MODE     = 8'hE0;

  // ==========================================================
  // field positions
  localparam int          BIT_EXT      = 0;
  localparam int          BIT_T0       = 4;
  localparam int          BIT_GIE      = 7;
  localparam int          EDGE_LSB     = 3;
  localparam int          MODE_SLEEP   = 0;
  localparam int          MODE_GREEN   = 1;
  localparam int          MODE_SLOW    = 2;

  // ==========================================================
  // reset values and codes
  localparam logic [7:0]  P1WAKE_RST   = 8'h00;
  localparam logic [1:0]  EDGE_RST     = 2'h0;
  localparam logic [1:0]  STACK_POINTER_REG_RST     = 2'h3;
  localparam logic [1:0]  EDGE_RISE    = 2'h1;
  localparam logic [1:0]  EDGE_FALL    = 2'h2;
  localparam logic [1:0]  EDGE_BOTH    = 2'h3;
  localparam int          PC_W         = 12;
  localparam logic [11:0] VECTOR_ADDR  = 12'h008;
  localparam int          WAKE_CLOCKS  = 2048;

  // ==========================================================
  // operating modes
  typedef enum logic [4:0] {
    ST_NORMAL = 5'b00001,
    ST_SLOW   = 5'b00010,
    ST_SLEEP  = 5'b00100,
    ST_GREEN  = 5'b01000,
    ST_WARM   = 5'b10000
  } wic_mode_type;

endpackage

// ---- hdl/wic_pin_sync.sv ----
/*
  two-flop synchroniser for a group of pins with a change detector.
  assumes pins are asynchronous to i_mclk.
*/
`timescale 1ns/10ps
module wic_pin_sync #(
  parameter int W = 8
) (
  input  wire logic         i_mclk,
  input  wire logic         i_rstn,
  input  wire logic [W-1:0] i_pin,
  output logic      [W-1:0] o_level,
  output logic      [W-1:0] o_change
);
  logic [W-1:0] meta;
  logic [W-1:0] prev;
  logic [2:0]   armed;

  // ==========================================================
  // first stage feeds only the second
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      meta    <= '0;
      o_level <= '0;
      prev    <= '0;
      armed   <= '0;
    end else begin
      meta    <= i_pin;
      o_level <= meta;
      prev    <= o_level;
      armed   <= {armed[1:0], 1'b1};
    end
  end

  // either direction counts as a change; quiet until history holds real
  // pin levels, so a pin idling high gives no false change after reset
  assign o_change = (o_level ^ prev) & {W{armed[2]}};
endmodule

// ---- hdl/wic_osc_wait.sv ----
/*
  oscillator settling counter: counts oscillator ticks after start.
  assumes i_tick is a one-cycle enable pulse on i_mclk.
*/
`timescale 1ns/10ps
module wic_osc_wait #(
  parameter int COUNT = 2048
) (
  input  wire logic i_mclk,
  input  wire logic i_rstn,
  input  wire logic i_run,
  input  wire logic i_tick,
  output logic      o_done
);
  localparam int CW = $clog2(COUNT + 1);
  localparam logic [CW-1:0] LAST = CW'(COUNT - 1);
  logic [CW-1:0] cnt;

  // ==========================================================
  // cleared whenever not waiting so each wake starts afresh
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      cnt    <= '0;
      o_done <= 1'b0;
    end else if (!i_run) begin
      cnt    <= '0;
      o_done <= 1'b0;
    end else if (i_tick && !o_done) begin
      cnt    <= cnt + CW'(1);
      o_done <= (cnt == LAST);
    end
  end
endmodule

// ---- testbench/wic_core_model.sv ----
/*
  far-side model: high-speed oscillator ticks and the core's return from
  interrupt service.
  assumes the block's strobes are registered on i_mclk.
*/
`timescale 1ns/10ps
module wic_core_model #(
  parameter int RETURN_FROM_IRQ_DELAY = 20
) (
  input  wire logic i_mclk,
  input  wire logic i_rstn,
  input  wire logic i_hosc_enable,
  input  wire logic i_tick_allow,
  input  wire logic i_vector_load,
  output logic      o_hosc_tick,
  output logic      o_return_from_irq
);
  logic [7:0] return_from_irq_count;

  // ==========================================================
  // oscillator: one tick every second cycle while allowed, none in sleep (ticks continue in green)
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_hosc_tick <= 1'b0;
    end else begin
      o_hosc_tick <= i_tick_allow & i_hosc_enable & !o_hosc_tick;
    end
  end

  // ==========================================================
  // core: service routine runs a while, then returns once per vector
  always_ff @(posedge i_mclk or negedge i_rstn) begin
    if (!i_rstn) begin
      return_from_irq_count <= 8'h00;
      o_return_from_irq     <= 1'b0;
    end else begin
      if (i_vector_load) begin
        return_from_irq_count <= 8'(RETURN_FROM_IRQ_DELAY);
      end else if (return_from_irq_count != 8'h00) begin
        return_from_irq_count <= return_from_irq_count - 8'h01;
      end
      o_return_from_irq <= (return_from_irq_count == 8'h01);
    end
  end
endmodule

// ---- testbench/wic_top_bench.sv ----
/*
  self-checking bench for the wake-up and interrupt control block.
  assumes nothing of slave latency: the master waits for waitrequest low.
*/
`timescale 1ns/10ps
module wic_top_bench;
  import wic_pkg::*;
  localparam int WCOUNT = 4;
  localparam int LIMIT  = 20000;
  logic        clk, rstn, rd, wr, tmr, tick, return_from_irq, allow;
  logic [7:0]  addr, wdata, rdata, p0, p1, got;
  logic        waitreq, run, hosc, vload, push;
  logic [11:0] vaddr, last_addr;
  logic        last_push;
  int          mismatches, compares, vec_count, cycles, i;

  wic_top #(.WAKE_COUNT(WCOUNT)) wic_top_inst (
    .i_mclk(clk), .i_rstn(rstn), .i_avs_address(addr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wdata), .o_avs_readdata(rdata),
    .o_avs_waitrequest(waitreq), .i_port0(p0), .i_port1(p1),
    .i_timer0_ovf(tmr), .i_hosc_tick(tick), .i_return_from_irq(return_from_irq), .o_core_run(run),
    .o_hosc_enable(hosc), .o_vector_load(vload), .o_vector_addr(vaddr),
    .o_stack_push(push));

  wic_core_model wic_core_model_inst (
    .i_mclk(clk), .i_rstn(rstn), .i_hosc_enable(hosc), .i_tick_allow(allow),
    .i_vector_load(vload), .o_hosc_tick(tick), .o_return_from_irq(return_from_irq));

  // ==========================================================
  // clock, timeout and vector monitor (sampled mid-cycle)
  always #20 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      mismatches++;
      $display("mismatch at %0t: timeout", $time);
      end_of_test();
    end
  end
  always @(negedge clk) begin
    if (vload === 1'b1) begin
      vec_count++;
      last_addr = vaddr;
      last_push = push;
    end
  end

  // ==========================================================
  // reporting
  task automatic check(input logic [7:0] g, input logic [7:0] e, input string m);
    compares++;
    if (g !== e) begin
      mismatches++;
      $display("mismatch at %0t: %s got %h expected %h", $time, m, g, e);
    end
  endtask

  task automatic end_of_test();
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // ==========================================================
  // Avalon master: hold request until waitrequest sampled low at a rising
  // edge; read data taken at that same edge, then release
  task automatic bus(input logic is_rd, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    rd    <= is_rd;
    wr    <= !is_rd;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    while (waitreq !== 1'b0) begin
      @(posedge clk);
    end
    got = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic wrr(input logic [7:0] a, input logic [7:0] d);
    bus(1'b0, a, d);
  endtask

  task automatic rdc(input logic [7:0] a, input logic [7:0] e, input string m);
    bus(1'b1, a, 8'h00);
    check(got, e, m);
  endtask

  // far-side stimulus: one-cycle overflow pulse, settle waits
  task automatic tpulse();
    @(posedge clk);
    tmr <= 1'b1;
    @(posedge clk);
    tmr <= 1'b0;
  endtask

  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask

  // ==========================================================
  // main sequence
  initial begin
    {clk, rstn, rd, wr, tmr, allow} = '0;
    {addr, wdata, p0, p1} = '0;
    {mismatches, compares, vec_count, cycles} = '0;
    repeat (16) @(posedge clk);
    rstn <= 1'b1;
    // reset values and write-only wake enables
    rdc(IDX_IRQ_EN, 8'h00, "enables reset");
    rdc(IDX_STACK, {6'h00, STACK_POINTER_REG_RST}, "stack reset");
    rdc(IDX_IRQ_REQ, 8'h00, "flags reset");
    rdc(IDX_MODE, 8'h01, "mode reset");
    wrr(IDX_P1WAKE, 8'hA5);
    rdc(IDX_P1WAKE, 8'h00, "wake enable read");
    wrr(IDX_P1WAKE, 8'h00);
    // every edge select code, rising then falling, enables clear
    for (i = 0; i < 4; i++) begin
      wrr(IDX_EDGE, 8'(i) << EDGE_LSB);
      p0[0] <= 1'b1;
      idle(6);
      rdc(IDX_IRQ_REQ, {7'h00, i[0]}, "flag on rise");
      wrr(IDX_IRQ_REQ, 8'h00);
      p0[0] <= 1'b0;
      idle(6);
      rdc(IDX_IRQ_REQ, {7'h00, i[1]}, "flag on fall");
      wrr(IDX_IRQ_REQ, 8'h00);
    end
    tpulse();
    rdc(IDX_IRQ_REQ, 8'h10, "timer flag");
    check(8'(vec_count), 8'h00, "vector with enables clear");
    // timer interrupt: gated by global enable, vector 8, cleared on entry
    wrr(IDX_IRQ_EN, 8'h10);
    idle(10);
    check(8'(vec_count), 8'h00, "vector without global");
    wrr(IDX_STACK, 8'h83);
    idle(4);
    check(8'(vec_count), 8'h01, "timer vector taken");
    check(last_addr[7:0], VECTOR_ADDR[7:0], "vector address");
    check({7'h00, last_push}, 8'h01, "stack push");
    rdc(IDX_STACK, 8'h03, "global cleared");
    wrr(IDX_IRQ_REQ, 8'h00);
    idle(30);
    rdc(IDX_STACK, 8'h83, "global restored");
    check(8'(vec_count), 8'h01, "no retake");
    // power-down: only a pin change wakes, then oscillator settling
    wrr(IDX_IRQ_EN, 8'h01);
    wrr(IDX_MODE, 8'h01);
    idle(1);
    check({6'h00, run, hosc}, 8'h00, "halted in sleep");
    tpulse();
    p1[1] <= 1'b1;
    idle(10);
    rdc(IDX_MODE, 8'h04, "still asleep");
    p0[0] <= 1'b1;
    idle(20);
    rdc(IDX_MODE, 8'h10, "warm-up waits ticks");
    check({6'h00, run, hosc}, 8'h01, "warm-up outputs");
    allow <= 1'b1;
    for (i = 0; i < 100 && run !== 1'b1; i++) @(negedge clk);
    rdc(IDX_MODE, 8'h01, "woke to normal");
    wrr(IDX_IRQ_REQ, 8'h00);
    check(8'(vec_count), 8'h02, "latched edge serviced");
    idle(30);
    // green: no settling wait, returns to the mode it left
    wrr(IDX_IRQ_EN, 8'h00);
    wrr(IDX_MODE, 8'h04);
    wrr(IDX_MODE, 8'h02);
    rdc(IDX_MODE, 8'h08, "green from slow");
    check({6'h00, run, hosc}, 8'h01, "green clock runs");
    allow <= 1'b0;
    tpulse();
    idle(2);
    rdc(IDX_MODE, 8'h02, "timer wakes to slow");
    wrr(IDX_MODE, 8'h00);
    wrr(IDX_P1WAKE, 8'h02);
    wrr(IDX_MODE, 8'h02);
    rdc(IDX_MODE, 8'h08, "green from normal");
    p1[1] <= 1'b0;
    idle(8);
    rdc(IDX_MODE, 8'h01, "falling pin wakes");
    wrr(IDX_MODE, 8'h02);
    p0[5] <= 1'b1;
    idle(8);
    rdc(IDX_MODE, 8'h01, "port 0 always wakes");
    end_of_test();
  end
endmodule
